// ===== common/phy_mgmt_pkg.sv
// constants, field layouts and frame states for the management register slice
package phy_mgmt_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MSG_W = 11;
  localparam int unsigned EN_W = 8;
  localparam int unsigned FLAG_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned HDR_BITS = 13;

  // register addresses
  localparam logic [4:0] LOCAL_NP_ADDR = 5'h07;
  localparam logic [4:0] PARTNER_NP_ADDR = 5'h08;
  localparam logic [4:0] RX_ERR_CNT_ADDR = 5'h15;
  localparam logic [4:0] INT_CTRL_ADDR = 5'h1b;
  localparam logic [4:0] PHY_CTRL_ADDR = 5'h1f;

  // field positions
  localparam int unsigned INT_POL_BIT = 9;
  localparam int unsigned EN_FLAG_MSB = 7;
  localparam int unsigned EN_FLAG_LSB = 3;
  localparam int unsigned NP_NEXT_BIT = 15;
  localparam int unsigned NP_MSG_PAGE_BIT = 13;
  localparam int unsigned NP_ACK2_BIT = 12;
  localparam int unsigned HDR_OP_MSB = 11;
  localparam int unsigned HDR_OP_LSB = 10;
  localparam int unsigned HDR_PHY_MSB = 9;
  localparam int unsigned HDR_PHY_LSB = 5;
  localparam int unsigned HDR_REG_MSB = 4;

  // reset values
  localparam logic NP_NEXT_RESET = 1'b0;
  localparam logic NP_MSG_PAGE_RESET = 1'b1;
  localparam logic NP_ACK2_RESET = 1'b0;
  localparam logic NP_TOGGLE_RESET = 1'b0;
  localparam logic [10:0] NP_MSG_RESET = 11'h001;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] LOCAL_NP_WORD_RESET = 16'h2001;
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam logic [4:0] INT_FLAG_RESET = 5'h00;
  localparam logic INT_POL_RESET = 1'b0;
  localparam logic [2:0] UNUSED_FLAGS = 3'h0;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // serial frame
  localparam logic [4:0] DEFAULT_PHY_ADDR = 5'h01;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [5:0] BIT_ONE = 6'h01;
  localparam logic [5:0] BIT_ZERO = 6'h00;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int unsigned HDR_ST_BIT = 12;

  typedef enum logic [3:0] {
    ST_PRE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_TA = 4'b0100,
    ST_DATA = 4'b1000
  } frame_state_type;

endpackage : phy_mgmt_pkg

// ===== common/mgmt_access_if.sv
// register access strobes between the serial slave and the register bank
`timescale 1ns/100ps
interface mgmt_access_if;
  import phy_mgmt_pkg::*;
  logic rd;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport serial (output rd, output wr, output addr, output wdata,
                  input rdata);
  modport bank (input rd, input wr, input addr, input wdata,
                output rdata);
endinterface : mgmt_access_if

// ===== verilog/mdio_serial_slave.sv
// serial management frame slave: turns frames into register strobes
`timescale 1ns/100ps
module mdio_serial_slave #(
  parameter logic [4:0] PHY_ADDRESS = phy_mgmt_pkg::DEFAULT_PHY_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  mgmt_access_if.serial acc
);
  import phy_mgmt_pkg::*;

  logic mdc_meta, mdc_sync, mdc_last;
  logic mdio_meta, mdio_sync;
  frame_state_type state;
  logic [CNT_W-1:0] bit_cnt;
  logic [HDR_BITS-1:0] hdr;
  logic [DATA_W-1:0] dsr;
  logic is_read;

  //////////////////////////////////////////////////////////////////////////
  // decode of the header as it completes
  wire mdc_rise = mdc_sync & ~mdc_last;
  wire [HDR_BITS-1:0] next_hdr = {hdr[HDR_BITS-2:0], mdio_sync};
  wire [1:0] hdr_op = next_hdr[HDR_OP_MSB:HDR_OP_LSB];
  wire [4:0] hdr_phy = next_hdr[HDR_PHY_MSB:HDR_PHY_LSB];
  wire [4:0] hdr_reg = next_hdr[HDR_REG_MSB:0];
  wire hdr_ok = next_hdr[HDR_ST_BIT] && (hdr_phy == PHY_ADDRESS) &&
                ((hdr_op == OP_READ) || (hdr_op == OP_WRITE));
  wire [DATA_W-1:0] shifted = {dsr[DATA_W-2:0], mdio_sync};

  //////////////////////////////////////////////////////////////////////////
  // pins come from the master's clock, so two flops before any use
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mdc_meta <= 1'b0;
      mdc_sync <= 1'b0;
      mdc_last <= 1'b0;
      mdio_meta <= 1'b1;
      mdio_sync <= 1'b1;
    end else begin
      mdc_meta <= mdc_i;
      mdc_sync <= mdc_meta;
      mdc_last <= mdc_sync;
      mdio_meta <= mdio_i;
      mdio_sync <= mdio_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // every frame needs a full preamble; suppressed preambles are not taken
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_PRE;
      bit_cnt <= BIT_ZERO;
      hdr <= '0;
      dsr <= WORD_RESET;
      is_read <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      acc.rd <= 1'b0;
      acc.wr <= 1'b0;
      acc.addr <= '0;
      acc.wdata <= WORD_RESET;
    end else begin
      acc.rd <= 1'b0;
      acc.wr <= 1'b0;
      // snapshot taken while the bank applies its read side effects
      if (acc.rd) begin
        dsr <= acc.rdata;
      end
      if (mdc_rise) begin
        unique case (state)
          ST_PRE: begin
            if (mdio_sync) begin
              if (bit_cnt != PRE_LEN) begin
                bit_cnt <= bit_cnt + BIT_ONE;
              end
            end else if (bit_cnt == PRE_LEN) begin
              state <= ST_HDR;
              bit_cnt <= BIT_ZERO;
            end else begin
              bit_cnt <= BIT_ZERO;
            end
          end
          ST_HDR: begin
            hdr <= next_hdr;
            if (bit_cnt == HDR_LAST) begin
              bit_cnt <= BIT_ZERO;
              state <= hdr_ok ? ST_TA : ST_PRE;
              is_read <= (hdr_op == OP_READ);
              acc.addr <= hdr_reg;
            end else begin
              bit_cnt <= bit_cnt + BIT_ONE;
            end
          end
          ST_TA: begin
            if (bit_cnt == BIT_ZERO) begin
              bit_cnt <= BIT_ONE;
              if (is_read) begin
                acc.rd <= 1'b1;
                mdio_oe_o <= 1'b1;
                mdio_o <= 1'b0;
              end
            end else begin
              state <= ST_DATA;
              bit_cnt <= BIT_ZERO;
              if (is_read) begin
                mdio_o <= dsr[DATA_W-1];
                dsr <= {dsr[DATA_W-2:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            if (is_read) begin
              mdio_o <= dsr[DATA_W-1];
              dsr <= {dsr[DATA_W-2:0], 1'b0};
            end else begin
              dsr <= shifted;
            end
            if (bit_cnt == DATA_LAST) begin
              state <= ST_PRE;
              bit_cnt <= BIT_ZERO;
              mdio_oe_o <= 1'b0;
              mdio_o <= 1'b0;
              if (!is_read) begin
                acc.wr <= 1'b1;
                acc.wdata <= shifted;
              end
            end else begin
              bit_cnt <= bit_cnt + BIT_ONE;
            end
          end
          default: begin
            state <= ST_PRE;
            bit_cnt <= BIT_ZERO;
          end
        endcase
      end
    end
  end

endmodule : mdio_serial_slave

// ===== verilog/phy_nextpage_interrupt_regs.sv
// next-page words, receive error counter and interrupt control/status
`timescale 1ns/100ps

// Notes on behaviour
// - local next-page compliance bit is writable, resets to 0
// - local toggle bit read-only, shows last transmitted toggle, resets 0
// - local 11-bit message field writable, resets to 001
// - partner next-page bit read-only: more pages follow or last page
// - partner acknowledge bit read-only, resets to 0
// - partner able-to-act bit read-only
// - partner toggle bit exposed read-only as received
// - read-only 16-bit receive error counter, resets to zero
// - jabber interrupt enable, writable, resets 0
// - receive error interrupt enable, writable, resets 0
// - page received interrupt enable, writable, resets 0
// - parallel detect fault interrupt enable, writable, resets 0
// - partner acknowledge interrupt enable, writable, resets 0
// - link down interrupt enable, writable, resets 0
// - remote fault interrupt enable, writable, resets 0
// - link up interrupt enable, writable, resets 0
// - jabber flag set on event, cleared by reading, resets 0
// - receive error flag set on event, cleared by reading, resets 0
// - page received flag set on event, cleared by reading, resets 0
// - parallel detect fault flag set on event, cleared by read
// - partner acknowledge flag set on event, cleared by read
// - interrupt pin active high when polarity bit is 1, else active low
module phy_nextpage_interrupt_regs #(
  parameter logic [4:0] PHY_ADDRESS = phy_mgmt_pkg::DEFAULT_PHY_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic tx_toggle_i,
  input wire logic partner_page_valid_i,
  input wire logic [phy_mgmt_pkg::DATA_W-1:0] partner_page_i,
  input wire logic jabber_evt_i,
  input wire logic rx_error_i,
  input wire logic page_rx_evt_i,
  input wire logic pd_fault_evt_i,
  input wire logic lp_ack_evt_i,
  output logic [phy_mgmt_pkg::DATA_W-1:0] local_np_o,
  output logic intr_o
);
  import phy_mgmt_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  //////////////////////////////////////////////////////////////////////////
  // serial slave
  mgmt_access_if acc();

  mdio_serial_slave #(
    .PHY_ADDRESS(PHY_ADDRESS)
  ) u_serial (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .acc(acc)
  );

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic np_next;
  logic np_msg_page;
  logic np_ack2;
  logic np_toggle;
  logic [MSG_W-1:0] np_msg;
  logic [DATA_W-1:0] partner_word;
  logic [DATA_W-1:0] rx_err_count;
  logic [EN_W-1:0] int_enable;
  logic [FLAG_W-1:0] int_flags;
  logic int_polarity;

  //////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_local = acc.wr & addr_hit(acc.addr, LOCAL_NP_ADDR);
  wire wr_int = acc.wr & addr_hit(acc.addr, INT_CTRL_ADDR);
  wire wr_ctrl = acc.wr & addr_hit(acc.addr, PHY_CTRL_ADDR);
  // a read pulse clears the flags; snapshot lands in the same cycle
  wire clr_flags = acc.rd & addr_hit(acc.addr, INT_CTRL_ADDR);

  // flag order: jabber, rx error, page received, pd fault, partner ack
  wire [FLAG_W-1:0] event_vec = {jabber_evt_i, rx_error_i, page_rx_evt_i,
                                 pd_fault_evt_i, lp_ack_evt_i};
  // an event in the clearing cycle is kept: set beats clear
  wire [FLAG_W-1:0] next_int_flags =
    (int_flags & ~{FLAG_W{clr_flags}}) | event_vec;

  wire int_active =
    |(int_flags & int_enable[EN_FLAG_MSB:EN_FLAG_LSB]);
  wire next_intr = int_polarity ? int_active : ~int_active;

  // counter sticks at all ones rather than wrapping to a small value
  wire count_step = rx_error_i && (rx_err_count != CNT_MAX);
  wire [DATA_W-1:0] next_rx_err_count =
    count_step ? rx_err_count + CNT_ONE : rx_err_count;

  wire [DATA_W-1:0] local_word = {np_next, 1'b0, np_msg_page, np_ack2,
                                  np_toggle, np_msg};
  wire [DATA_W-1:0] int_word = {int_enable, int_flags, UNUSED_FLAGS};
  wire [DATA_W-1:0] ctrl_word =
    DATA_W'({int_polarity}) << INT_POL_BIT;

  // unmapped addresses read as zero
  assign acc.rdata =
    addr_hit(acc.addr, LOCAL_NP_ADDR) ? local_word :
    addr_hit(acc.addr, PARTNER_NP_ADDR) ? partner_word :
    addr_hit(acc.addr, RX_ERR_CNT_ADDR) ? rx_err_count :
    addr_hit(acc.addr, INT_CTRL_ADDR) ? int_word :
    addr_hit(acc.addr, PHY_CTRL_ADDR) ? ctrl_word : WORD_RESET;

  //////////////////////////////////////////////////////////////////////////
  // local next-page word
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      np_next <= NP_NEXT_RESET;
      np_msg_page <= NP_MSG_PAGE_RESET;
      np_ack2 <= NP_ACK2_RESET;
      np_msg <= NP_MSG_RESET;
    end else if (wr_local) begin
      np_next <= acc.wdata[NP_NEXT_BIT];
      np_msg_page <= acc.wdata[NP_MSG_PAGE_BIT];
      np_ack2 <= acc.wdata[NP_ACK2_BIT];
      np_msg <= acc.wdata[MSG_W-1:0];
    end
  end

  // toggle follows the transmitter; writes never reach it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      np_toggle <= NP_TOGGLE_RESET;
    end else begin
      np_toggle <= tx_toggle_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // partner next-page word, held until the next page arrives
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      partner_word <= WORD_RESET;
    end else if (partner_page_valid_i) begin
      partner_word <= partner_page_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive error counter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_err_count <= WORD_RESET;
    end else begin
      rx_err_count <= next_rx_err_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt control and status
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_enable <= INT_EN_RESET;
    end else if (wr_int) begin
      int_enable <= acc.wdata[DATA_W-1:EN_W];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_flags <= INT_FLAG_RESET;
    end else begin
      int_flags <= next_int_flags;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_polarity <= INT_POL_RESET;
    end else if (wr_ctrl) begin
      int_polarity <= acc.wdata[INT_POL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs; the pin idles inactive, high for the default level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      intr_o <= 1'b1;
      local_np_o <= LOCAL_NP_WORD_RESET;
    end else begin
      intr_o <= next_intr;
      local_np_o <= local_word;
    end
  end

endmodule : phy_nextpage_interrupt_regs

// ===== dv/nextpage_regs_sva.sv
// port checker for the next-page and interrupt register slice
`timescale 1ns/100ps
module nextpage_regs_sva import phy_mgmt_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic tx_toggle_i,
  input wire logic partner_page_valid_i,
  input wire logic jabber_evt_i,
  input wire logic rx_error_i,
  input wire logic page_rx_evt_i,
  input wire logic pd_fault_evt_i,
  input wire logic lp_ack_evt_i,
  input wire logic [DATA_W-1:0] local_np_o,
  input wire logic intr_o
);
  logic [3:0] since_mdc;
  logic [3:0] quiet;
  logic [4:0] oe_rises;
  logic mdc_q;
  wire logic evt = jabber_evt_i | rx_error_i | page_rx_evt_i
                   | pd_fault_evt_i | lp_ack_evt_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  //////////////////////////////////////////////////////////////////////////
  // since_mdc and quiet saturate: a long idle stretch must not wrap back to zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_mdc <= 4'h0;
      quiet <= 4'h0;
      oe_rises <= 5'h00;
      mdc_q <= 1'b0;
    end else begin
      since_mdc <= mdc_i ? 4'h0 : since_mdc + {3'h0, since_mdc != 4'hf};
      quiet <= (mdc_i | evt) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
      oe_rises <= mdio_oe_o ? oe_rises + {4'h0, mdc_i & ~mdc_q} : 5'h00;
      mdc_q <= mdc_i;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_reset_vals;
    $rose(rst_b_i) |-> local_np_o == LOCAL_NP_WORD_RESET && intr_o
      && !mdio_oe_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong values after reset");
  property p_toggle_hi;
    tx_toggle_i [*3] |-> local_np_o[11];
  endproperty
  a_toggle_hi: assert property (p_toggle_hi)
    else $error("toggle bit not following high");
  property p_toggle_lo;
    !tx_toggle_i [*3] |-> !local_np_o[11];
  endproperty
  a_toggle_lo: assert property (p_toggle_lo)
    else $error("toggle bit not following low");
  property p_np_by_write;
    $changed({local_np_o[15:12], local_np_o[10:0]}) |-> since_mdc != 4'hf;
  endproperty
  a_np_by_write: assert property (p_np_by_write)
    else $error("next-page word changed without a frame");
  property p_intr_quiet;
    quiet == 4'hf |-> $stable(intr_o);
  endproperty
  a_intr_quiet: assert property (p_intr_quiet)
    else $error("interrupt moved with no cause");
  property p_oe_cause;
    $rose(mdio_oe_o) |-> !mdio_o && since_mdc != 4'hf;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("drive started outside a frame");
  property p_oe_len;
    mdio_oe_o |-> oe_rises <= 5'h11;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("drive held too many bits");
  property p_idle_low;
    !mdio_oe_o |-> !mdio_o;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("data output high while released");
  c_intr: cover property ($fell(intr_o));
  c_drive: cover property ($rose(mdio_oe_o));
  c_page: cover property (partner_page_valid_i);
endmodule : nextpage_regs_sva

// ===== dv/mdio_master_model.sv
// serial management master model: framing, bit timing, line release
`timescale 1ns/100ps
module mdio_master_model import phy_mgmt_pkg::*; (
  input wire logic core_clk_i,
  input wire logic mdio_wire_i,
  output logic mdc_o,
  output logic mdio_drv_o,
  output logic mdio_en_o
);
  // clock stands low between frames
  initial begin
    mdc_o = 1'b0;
    mdio_drv_o = 1'b1;
    mdio_en_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // 4 cycles low then 5 high: device needs at least 4 of each
  task automatic bit_cyc(input logic b, input logic en, output logic s);
    @(posedge core_clk_i);
    mdc_o <= 1'b0;
    mdio_drv_o <= b;
    mdio_en_o <= en;
    repeat (4) @(posedge core_clk_i);
    s = mdio_wire_i;
    mdc_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask : bit_cyc
  // whole frame with its own preamble; read releases the line at turnaround
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(f[i], (op == OP_WRITE) || (i > 17), s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    @(posedge core_clk_i);
    mdc_o <= 1'b0;
    mdio_en_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : xfer
endmodule : mdio_master_model

// ===== dv/tb_top.sv
// testbench: registers over the serial port, events and interrupt pin
`timescale 1ns/100ps
module tb_top;
  import phy_mgmt_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tx_toggle = 1'b0;
  logic page_valid = 1'b0;
  logic [DATA_W-1:0] page = 16'h0000;
  logic [4:0] evt = 5'h00;
  logic mdc;
  logic m_drv;
  logic m_en;
  logic mdio_out;
  logic mdio_oe;
  logic intr;
  logic [DATA_W-1:0] local_np;
  wire logic mdio_wire;
  int n_errors = 0;
  int comparisons = 0;
  always #5 core_clk_i = ~core_clk_i;
  // pull-up holds the line high once every party lets go
  assign mdio_wire = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);
  mdio_master_model mdio_master_model_i (.core_clk_i(core_clk_i),
    .mdio_wire_i(mdio_wire), .mdc_o(mdc), .mdio_drv_o(m_drv),
    .mdio_en_o(m_en));
  phy_nextpage_interrupt_regs phy_nextpage_interrupt_regs_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc),
    .mdio_i(mdio_wire), .mdio_o(mdio_out), .mdio_oe_o(mdio_oe),
    .tx_toggle_i(tx_toggle), .partner_page_valid_i(page_valid),
    .partner_page_i(page), .jabber_evt_i(evt[4]), .rx_error_i(evt[3]),
    .page_rx_evt_i(evt[2]), .pd_fault_evt_i(evt[1]),
    .lp_ack_evt_i(evt[0]), .local_np_o(local_np), .intr_o(intr));
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_pin
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    mdio_master_model_i.xfer(OP_WRITE, DEFAULT_PHY_ADDR, a, d, x);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    mdio_master_model_i.xfer(OP_READ, DEFAULT_PHY_ADDR, a, 16'h0000, d);
    check(d, e);
  endtask : rdc
  // flag lands one cycle after the event, the pin one more
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    evt[k] <= 1'b1;
    @(posedge core_clk_i);
    evt[k] <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk_i);
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [15:0] x;
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rdc(LOCAL_NP_ADDR, 16'h2001);
    rdc(PARTNER_NP_ADDR, 16'h0000);
    rdc(RX_ERR_CNT_ADDR, 16'h0000);
    rdc(INT_CTRL_ADDR, 16'h0000);
    rdc(5'h03, 16'h0000);
    $display("test reset_values done");
    wr(LOCAL_NP_ADDR, 16'hffff);
    rdc(LOCAL_NP_ADDR, 16'hb7ff);
    tx_toggle <= 1'b1;
    wr(LOCAL_NP_ADDR, 16'h0000);
    rdc(LOCAL_NP_ADDR, 16'h0800);
    check(local_np, 16'h0800);
    $display("test local_page done");
    // frames for another station or with a bad opcode change nothing
    mdio_master_model_i.xfer(OP_WRITE, 5'h02, LOCAL_NP_ADDR, 16'hffff,
                             x);
    rdc(LOCAL_NP_ADDR, 16'h0800);
    mdio_master_model_i.xfer(OP_READ, 5'h02, INT_CTRL_ADDR, 16'h0000,
                             x);
    check(x, 16'hffff);
    mdio_master_model_i.xfer(2'h3, DEFAULT_PHY_ADDR, INT_CTRL_ADDR,
                             16'h0000, x);
    check(x, 16'hffff);
    $display("test refused done");
    page <= 16'hd8a5;
    page_valid <= 1'b1;
    @(posedge core_clk_i);
    page_valid <= 1'b0;
    wr(PARTNER_NP_ADDR, 16'h0000);
    rdc(PARTNER_NP_ADDR, 16'hd8a5);
    $display("test partner_page done");
    wr(INT_CTRL_ADDR, 16'hffff);
    rdc(INT_CTRL_ADDR, 16'hff00);
    for (int j = 0; j < 5; j++) begin
      check_pin(intr, 1'b1);
      pulse(j);
      check_pin(intr, 1'b0);
      rdc(INT_CTRL_ADDR, 16'(16'hff08 << j) | 16'hff00);
      check_pin(intr, 1'b1);
    end
    pulse(3);
    pulse(3);
    wr(RX_ERR_CNT_ADDR, 16'h0000);
    rdc(RX_ERR_CNT_ADDR, 16'h0003);
    wr(INT_CTRL_ADDR, 16'h0000);
    pulse(4);
    check_pin(intr, 1'b1);
    rdc(INT_CTRL_ADDR, 16'h00c0);
    $display("test interrupts done");
    wr(PHY_CTRL_ADDR, 16'hffff);
    rdc(PHY_CTRL_ADDR, 16'h0200);
    check_pin(intr, 1'b0);
    wr(INT_CTRL_ADDR, 16'h2000);
    pulse(1);
    check_pin(intr, 1'b0);
    pulse(2);
    check_pin(intr, 1'b1);
    rdc(INT_CTRL_ADDR, 16'h2030);
    check_pin(intr, 1'b0);
    $display("test polarity done");
    give_verdict();
  end
endmodule : tb_top

bind phy_nextpage_interrupt_regs nextpage_regs_sva nextpage_regs_sva_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .tx_toggle_i(tx_toggle_i),
  .partner_page_valid_i(partner_page_valid_i),
  .jabber_evt_i(jabber_evt_i), .rx_error_i(rx_error_i),
  .page_rx_evt_i(page_rx_evt_i), .pd_fault_evt_i(pd_fault_evt_i),
  .lp_ack_evt_i(lp_ack_evt_i), .local_np_o(local_np_o), .intr_o(intr_o));
